// [hw/brc_pkg.sv]
// Shared constants and carrier types of the BCD clock/calendar core
package brc_pkg;
	localparam int OSC_HZ = 32768;
	localparam int RAM_WORDS = 96;

	localparam logic [6:0] A_SEC = 7'h00;
	localparam logic [6:0] A_HOUR = 7'h02;
	localparam logic [6:0] A_YEAR = 7'h06;
	localparam logic [6:0] A_AL0 = 7'h07;
	localparam logic [6:0] A_AL1_END = 7'h0E;
	localparam logic [6:0] A_CTRL = 7'h0F;
	localparam logic [6:0] A_STAT = 7'h10;
	localparam logic [6:0] A_TRKL = 7'h11;
	localparam logic [6:0] A_CLK_BEG = 7'h00;
	localparam logic [6:0] A_CLK_END = 7'h1F;
	localparam logic [6:0] A_RAM_BEG = 7'h20;
	localparam logic [6:0] A_RAM_END = 7'h7F;
	localparam logic [6:0] A_MIN = 7'h01;
	localparam logic [6:0] A_WDAY = 7'h03;
	localparam logic [6:0] A_DATE = 7'h04;
	localparam logic [6:0] A_MONTH = 7'h05;

	localparam int WR_BIT = 7;
	localparam int HR_12 = 6;
	localparam int HR_PM = 5;
	localparam int MON_CEN = 7;
	localparam int MASK_BIT = 7;
	localparam int CTL_ROUTE = 2;
	localparam int CTL_IE1 = 1;
	localparam int CTL_IE0 = 0;

	localparam logic [7:0] CTRL_RST = 8'h80;
	localparam logic [7:0] BCD_ZERO = 8'h00;
	localparam logic [7:0] BCD_ONE = 8'h01;
	localparam logic [7:0] BCD_59 = 8'h59;
	localparam logic [7:0] HR24_MAX = 8'h23;
	localparam logic [7:0] HR12_MAX = 8'h12;
	localparam logic [4:0] HR12_PRE = 5'h11;
	localparam logic [7:0] WDAY_MAX = 8'h07;
	localparam logic [7:0] MON_MAX = 8'h12;
	localparam logic [4:0] MON_FEB = 5'h02;
	localparam logic [7:0] YEAR_MAX = 8'h99;
	localparam logic [7:0] DAYS_28 = 8'h28;
	localparam logic [7:0] DAYS_29 = 8'h29;
	localparam logic [7:0] DAYS_30 = 8'h30;
	localparam logic [7:0] DAYS_31 = 8'h31;

	localparam logic [7:0] WM_TIME = 8'h7F;
	localparam logic [7:0] WM_WDAY = 8'h07;
	localparam logic [7:0] WM_DATE = 8'h3F;
	localparam logic [7:0] WM_MONTH = 8'h9F;
	localparam logic [7:0] WM_STAT = 8'h03;
	localparam logic [7:0] WM_ALL = 8'hFF;

	// Field order matches the address order, seconds in the low byte
	typedef struct packed {
		logic [7:0] year;
		logic [7:0] month;
		logic [7:0] date;
		logic [7:0] wday;
		logic [7:0] hour;
		logic [7:0] min;
		logic [7:0] sec;
	} brc_time_t;

	typedef struct packed {
		logic [7:0] wday;
		logic [7:0] hour;
		logic [7:0] min;
		logic [7:0] sec;
	} brc_alarm_t;

	localparam brc_time_t TIME_POR = '{year: 8'h00, month: 8'h01, date: 8'h01, wday: 8'h01,
		hour: 8'h00, min: 8'h00, sec: 8'h00};
endpackage

// [hw/brc_sync2.sv]
// Two-stage synchroniser for pins from outside the clk_sys domain
`timescale 1ns/100ps
`default_nettype none
module brc_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_ff;

	if (WIDTH < 1) begin : g_chk
		$error("WIDTH must be at least 1");
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta_ff <= '0;
			q <= '0;
		end else begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end
endmodule
`default_nettype wire

// [hw/brc_alarm_match.sv]
// Masked compare of the running time against one alarm
`timescale 1ns/100ps
`default_nettype none
module brc_alarm_match (
	input wire brc_pkg::brc_time_t tm,
	input wire brc_pkg::brc_alarm_t al,
	output logic hit
);
	// Mask set means the field is ignored
	assign hit = (al.sec[brc_pkg::MASK_BIT] | (al.sec[6:0] == tm.sec[6:0]))
		& (al.min[brc_pkg::MASK_BIT] | (al.min[6:0] == tm.min[6:0]))
		& (al.hour[brc_pkg::MASK_BIT] | (al.hour[6:0] == tm.hour[6:0]))
		& (al.wday[brc_pkg::MASK_BIT] | (al.wday[2:0] == tm.wday[2:0]));
endmodule
`default_nettype wire

// [hw/brc_rtc_core.sv]
// BCD clock/calendar with serial register access, shadow reads and two alarms
`timescale 1ns/100ps
`default_nettype none
module brc_rtc_core #(
	parameter int PRESCALE = brc_pkg::OSC_HZ
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic x1,
	input wire logic below_power_fail_threshold,
	output logic sdo,
	output logic sdo_oe,
	output logic irq_out_first_n,
	output logic irq_out_first_oe,
	output logic irq_out_second_n,
	output logic irq_out_second_oe
);
	localparam int DW = $clog2(PRESCALE);

	typedef enum logic [1:0] {PH_ADDR, PH_WR, PH_RD} brc_phase_t;

	if (PRESCALE < 2) begin : g_chk
		$error("PRESCALE must be at least 2");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] top,
		input logic [7:0] low);
		if (v == top) begin
			return {1'b1, low};
		end
		if (v[3:0] == 4'h9) begin
			return {1'b0, v[7:4] + 4'h1, 4'h0};
		end
		return {1'b0, v + 8'h01};
	endfunction

	function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
		logic leap;
		// Every fourth year is leap, good through 2099
		leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) :
			(y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
		case (m[4:0])
			brc_pkg::MON_FEB: return leap ? brc_pkg::DAYS_29 : brc_pkg::DAYS_28;
			5'h04, 5'h06, 5'h09, 5'h11: return brc_pkg::DAYS_30;
			default: return brc_pkg::DAYS_31;
		endcase
	endfunction

	function automatic brc_pkg::brc_time_t next_time(input brc_pkg::brc_time_t t);
		brc_pkg::brc_time_t n;
		logic [8:0] st;
		logic c;
		n = t;
		st = bcd_step(t.sec, brc_pkg::BCD_59, brc_pkg::BCD_ZERO);
		n.sec = st[7:0];
		c = st[8];
		if (c) begin
			st = bcd_step(t.min, brc_pkg::BCD_59, brc_pkg::BCD_ZERO);
			n.min = st[7:0];
			c = st[8];
		end
		if (c) begin
			if (t.hour[brc_pkg::HR_12]) begin
				st = bcd_step({3'b000, t.hour[4:0]}, brc_pkg::HR12_MAX, brc_pkg::BCD_ONE);
				n.hour[4:0] = st[4:0];
				if (t.hour[4:0] == brc_pkg::HR12_PRE) begin
					n.hour[brc_pkg::HR_PM] = ~t.hour[brc_pkg::HR_PM];
				end
				c = (t.hour[4:0] == brc_pkg::HR12_PRE) & t.hour[brc_pkg::HR_PM];
			end else begin
				// Bit 5 is simply the twenties digit here
				st = bcd_step({2'b00, t.hour[5:0]}, brc_pkg::HR24_MAX, brc_pkg::BCD_ZERO);
				n.hour[5:0] = st[5:0];
				c = st[8];
			end
		end
		if (c) begin
			st = bcd_step(t.wday, brc_pkg::WDAY_MAX, brc_pkg::BCD_ONE);
			n.wday = st[7:0];
			st = bcd_step(t.date, last_day(t.month, t.year), brc_pkg::BCD_ONE);
			n.date = st[7:0];
			c = st[8];
		end
		if (c) begin
			st = bcd_step({3'b000, t.month[4:0]}, brc_pkg::MON_MAX, brc_pkg::BCD_ONE);
			n.month[4:0] = st[4:0];
			c = st[8];
		end
		if (c) begin
			st = bcd_step(t.year, brc_pkg::YEAR_MAX, brc_pkg::BCD_ZERO);
			n.year = st[7:0];
			if (st[8]) begin
				n.month[brc_pkg::MON_CEN] = ~t.month[brc_pkg::MON_CEN];
			end
		end
		return n;
	endfunction

	function automatic logic [6:0] ptr_step(input logic [6:0] p);
		if (p == brc_pkg::A_CLK_END) begin
			return brc_pkg::A_CLK_BEG;
		end
		if (p == brc_pkg::A_RAM_END) begin
			return brc_pkg::A_RAM_BEG;
		end
		return p + 7'h01;
	endfunction

	function automatic logic [7:0] wmask(input logic [6:0] a);
		case (a)
			brc_pkg::A_SEC, brc_pkg::A_MIN, brc_pkg::A_HOUR: return brc_pkg::WM_TIME;
			brc_pkg::A_WDAY: return brc_pkg::WM_WDAY;
			brc_pkg::A_DATE: return brc_pkg::WM_DATE;
			brc_pkg::A_MONTH: return brc_pkg::WM_MONTH;
			brc_pkg::A_STAT: return brc_pkg::WM_STAT;
			default: return brc_pkg::WM_ALL;
		endcase
	endfunction

	logic pf_s;

	// Power-fail shuts out the clock register space only; user RAM stays open
	function automatic logic blocked(input logic [6:0] a);
		return pf_s & (a < brc_pkg::A_RAM_BEG);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pin sampling

	logic [4:0] pin_s;
	logic ce_s, sclk_s, sdi_s, x1_s;
	logic ce_d_ff, sclk_d_ff, x1_d_ff;
	logic ce_rise, sclk_rise, sclk_fall, x1_rise;

	brc_sync2 #(.WIDTH(5)) u_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.d({ce, sclk, sdi, x1, below_power_fail_threshold}),
		.q(pin_s)
	);

	assign {ce_s, sclk_s, sdi_s, x1_s, pf_s} = pin_s;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ce_d_ff <= 1'b0;
			sclk_d_ff <= 1'b0;
			x1_d_ff <= 1'b0;
		end else begin
			ce_d_ff <= ce_s;
			sclk_d_ff <= sclk_s;
			x1_d_ff <= x1_s;
		end
	end

	assign ce_rise = ce_s & ~ce_d_ff;
	assign sclk_rise = sclk_s & ~sclk_d_ff;
	assign sclk_fall = ~sclk_s & sclk_d_ff;
	assign x1_rise = x1_s & ~x1_d_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Serial framing

	brc_phase_t ph_ff;
	logic [2:0] bit_ff;
	logic [6:0] sh_ff, ptr_ff, rd_addr;
	logic [7:0] rx_byte, rd_data;
	logic byte_done, wrap_clk, rd_go, wr_en, sec_wr;

	assign rx_byte = {sh_ff, sdi_s};
	assign byte_done = ce_s & sclk_rise & (bit_ff == 3'h7);
	assign wrap_clk = byte_done & (ph_ff != PH_ADDR) & (ptr_ff == brc_pkg::A_CLK_END);
	assign rd_addr = (ph_ff == PH_ADDR) ? rx_byte[6:0] : ptr_step(ptr_ff);
	assign rd_go = (ph_ff == PH_ADDR) ? ~rx_byte[brc_pkg::WR_BIT] : (ph_ff == PH_RD);
	assign wr_en = byte_done & (ph_ff == PH_WR) & ~blocked(ptr_ff);
	assign sec_wr = wr_en & (ptr_ff == brc_pkg::A_SEC);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ph_ff <= PH_ADDR;
			bit_ff <= '0;
			sh_ff <= '0;
			ptr_ff <= '0;
		end else if (!ce_s) begin
			ph_ff <= PH_ADDR;
			bit_ff <= '0;
		end else if (sclk_rise) begin
			bit_ff <= bit_ff + 3'h1;
			sh_ff <= rx_byte[6:0];
			if (bit_ff == 3'h7) begin
				if (ph_ff == PH_ADDR) begin
					ptr_ff <= rx_byte[6:0];
					ph_ff <= rx_byte[brc_pkg::WR_BIT] ? PH_WR : PH_RD;
				end else begin
					// Burst continues for as long as select stays high
					ptr_ff <= ptr_step(ptr_ff);
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Prescaler and time counters

	logic [DW-1:0] div_ff;
	logic tick, tick_d_ff;
	brc_pkg::brc_time_t time_ff, snap_ff, time_inc;

	assign tick = x1_rise & (div_ff == DW'(PRESCALE - 1));
	assign time_inc = next_time(time_ff);

	// Writing seconds restarts the second so the new value lasts a full second
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			div_ff <= '0;
			tick_d_ff <= 1'b0;
		end else begin
			tick_d_ff <= tick;
			if (sec_wr) begin
				div_ff <= '0;
			end else if (x1_rise) begin
				div_ff <= tick ? '0 : div_ff + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			time_ff <= brc_pkg::TIME_POR;
		end else if (wr_en && ptr_ff <= brc_pkg::A_YEAR) begin
			// Host writes win over a coinciding tick; values taken as BCD
			time_ff[{ptr_ff[2:0], 3'b000} +: 8] <= rx_byte & wmask(ptr_ff);
		end else if (tick) begin
			time_ff <= time_inc;
		end
	end

	// Reads come from this copy so a multi-byte read never tears
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			snap_ff <= brc_pkg::TIME_POR;
		end else if (ce_rise || wrap_clk) begin
			snap_ff <= time_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Alarm, control and RAM storage

	logic [7:0] al_ff [8];
	logic [7:0] ctrl_ff, trkl_ff;
	logic [7:0] ram_ff [brc_pkg::RAM_WORDS];

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			// All-zero alarm never matches, since weekday 0 never occurs
			for (int i = 0; i < 8; i++) begin
				al_ff[i] <= '0;
			end
		end else if (wr_en && ptr_ff >= brc_pkg::A_AL0 && ptr_ff <= brc_pkg::A_AL1_END) begin
			al_ff[3'(ptr_ff - brc_pkg::A_AL0)] <= rx_byte;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl_ff <= brc_pkg::CTRL_RST;
			trkl_ff <= '0;
		end else if (wr_en && ptr_ff == brc_pkg::A_CTRL) begin
			ctrl_ff <= rx_byte;
		end else if (wr_en && ptr_ff == brc_pkg::A_TRKL) begin
			trkl_ff <= rx_byte;
		end
	end

	// No reset on user RAM, as a battery-backed store would not have one
	always_ff @(posedge clk_sys) begin
		if (wr_en && ptr_ff >= brc_pkg::A_RAM_BEG) begin
			ram_ff[7'(ptr_ff - brc_pkg::A_RAM_BEG)] <= rx_byte;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Alarm flags and interrupt pins

	logic [1:0] match, flag_ff, flag_clr, act;
	logic irq_first_ff, irq_second_ff;

	for (genvar g = 0; g < 2; g++) begin : g_al
		brc_alarm_match u_match (
			.tm(time_ff),
			.al({al_ff[4*g+3], al_ff[4*g+2], al_ff[4*g+1], al_ff[4*g]}),
			.hit(match[g])
		);
	end

	// Writing 0 clears a flag; a match in the same cycle still sets it
	assign flag_clr = {2{wr_en & (ptr_ff == brc_pkg::A_STAT)}} & ~rx_byte[1:0];
	assign act = flag_ff & {ctrl_ff[brc_pkg::CTL_IE1], ctrl_ff[brc_pkg::CTL_IE0]};

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flag_ff <= '0;
		end else begin
			flag_ff <= (flag_ff & ~flag_clr) | ({2{tick_d_ff}} & match);
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq_first_ff <= 1'b1;
			irq_second_ff <= 1'b1;
		end else begin
			irq_first_ff <= ~(act[0] | (ctrl_ff[brc_pkg::CTL_ROUTE] & act[1]));
			irq_second_ff <= ~act[1];
		end
	end

	assign irq_out_first_n = irq_first_ff;
	assign irq_out_second_n = irq_second_ff;
	assign irq_out_first_oe = ~irq_first_ff;
	assign irq_out_second_oe = ~irq_second_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Read data path

	brc_pkg::brc_time_t rd_time;
	logic tx_oe_ff, sdo_ff;
	logic [7:0] tx_ff;

	// On a wrap the fresh copy is not yet in the shadow, so take the live time
	assign rd_time = wrap_clk ? time_ff : snap_ff;

	always_comb begin
		rd_data = '0;
		if (rd_addr >= brc_pkg::A_RAM_BEG) begin
			rd_data = ram_ff[7'(rd_addr - brc_pkg::A_RAM_BEG)];
		end else if (rd_addr <= brc_pkg::A_YEAR) begin
			rd_data = rd_time[{rd_addr[2:0], 3'b000} +: 8];
		end else if (rd_addr <= brc_pkg::A_AL1_END) begin
			rd_data = al_ff[3'(rd_addr - brc_pkg::A_AL0)];
		end else if (rd_addr == brc_pkg::A_CTRL) begin
			rd_data = ctrl_ff;
		end else if (rd_addr == brc_pkg::A_STAT) begin
			rd_data = {6'h00, flag_ff};
		end else if (rd_addr == brc_pkg::A_TRKL) begin
			rd_data = trkl_ff;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_ff <= '0;
			tx_oe_ff <= 1'b0;
			sdo_ff <= 1'b0;
		end else begin
			if (byte_done) begin
				tx_ff <= rd_data;
			end
			if (!ce_s) begin
				tx_oe_ff <= 1'b0;
			end else if (byte_done) begin
				tx_oe_ff <= rd_go & ~blocked(rd_addr);
			end
			if (sclk_fall) begin
				sdo_ff <= tx_ff[3'h7 - bit_ff];
			end
		end
	end

	assign sdo = sdo_ff;
	assign sdo_oe = tx_oe_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	logic eod_tick;
	assign eod_tick = tick & ~wr_en & (time_ff.sec == brc_pkg::BCD_59) & (time_ff.min == brc_pkg::BCD_59);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	property p_wrap_clk;
		byte_done && ph_ff != PH_ADDR && ptr_ff == brc_pkg::A_CLK_END |=> ptr_ff == brc_pkg::A_CLK_BEG;
	endproperty
	a_wrap_clk: assert property (p_wrap_clk) else $error("clock pointer did not wrap");

	property p_wrap_ram;
		byte_done && ph_ff != PH_ADDR && ptr_ff == brc_pkg::A_RAM_END |=> ptr_ff == brc_pkg::A_RAM_BEG;
	endproperty
	a_wrap_ram: assert property (p_wrap_ram) else $error("RAM pointer did not wrap");

	property p_snap;
		ce_rise |=> snap_ff == $past(time_ff);
	endproperty
	a_snap: assert property (p_snap) else $error("shadow not taken on select rise");

	property p_block;
		pf_s && byte_done && ph_ff == PH_WR && ptr_ff <= brc_pkg::A_YEAR && !tick |=> time_ff == $past(time_ff);
	endproperty
	a_block: assert property (p_block) else $error("time written during power fail");

	property p_wday;
		eod_tick && time_ff.hour == brc_pkg::HR24_MAX && time_ff.wday == brc_pkg::WDAY_MAX
			|=> time_ff.wday == brc_pkg::BCD_ONE && time_ff.hour == brc_pkg::BCD_ZERO;
	endproperty
	a_wday: assert property (p_wday) else $error("weekday did not roll to 1");

	property p_feb;
		eod_tick && time_ff.hour == brc_pkg::HR24_MAX && time_ff.month[4:0] == brc_pkg::MON_FEB
			&& time_ff.date == brc_pkg::DAYS_28 && time_ff.year[0] |=> time_ff.date == brc_pkg::BCD_ONE;
	endproperty
	a_feb: assert property (p_feb) else $error("February did not end on 28 in odd year");

	property p_pm;
		eod_tick && time_ff.hour[brc_pkg::HR_12] && time_ff.hour[4:0] == brc_pkg::HR12_PRE
			|=> time_ff.hour[brc_pkg::HR_PM] != $past(time_ff.hour[brc_pkg::HR_PM]);
	endproperty
	a_pm: assert property (p_pm) else $error("PM bit did not toggle at 12");

	property p_cent;
		eod_tick && time_ff.hour == brc_pkg::HR24_MAX && time_ff.year == brc_pkg::YEAR_MAX
			&& time_ff.month[4:0] == brc_pkg::MON_MAX && time_ff.date == brc_pkg::DAYS_31
			|=> time_ff.month[brc_pkg::MON_CEN] != $past(time_ff.month[brc_pkg::MON_CEN]);
	endproperty
	a_cent: assert property (p_cent) else $error("century bit did not toggle");

	property p_flag;
		tick_d_ff && match[0] |=> flag_ff[0];
	endproperty
	a_flag: assert property (p_flag) else $error("alarm match lost its flag");

	property p_irq;
		flag_ff[1] && ctrl_ff[brc_pkg::CTL_IE1] |=> !irq_out_second_n && irq_out_second_oe;
	endproperty
	a_irq: assert property (p_irq) else $error("second output not asserted");

	property p_clr;
		flag_clr[1] && !(tick_d_ff && match[1]) |=> ##1 irq_out_second_n;
	endproperty
	a_clr: assert property (p_clr) else $error("output held after flag clear");

	property p_ie_off;
		!ctrl_ff[brc_pkg::CTL_IE0] && !ctrl_ff[brc_pkg::CTL_IE1] |=> irq_out_first_n && irq_out_second_n;
	endproperty
	a_ie_off: assert property (p_ie_off) else $error("output asserted with enables off");
endmodule
`default_nettype wire

// [verif/brc_host_model.sv]
// Host model that drives the serial link of the clock core
`timescale 1ns/100ps
`default_nettype none
module brc_host_model (
	input wire logic clk_sys,
	input wire logic sdo,
	input wire logic sdo_oe,
	output logic ce,
	output logic sclk,
	output logic sdi
);
	logic [7:0] dat [8];
	logic oe_all;

	initial begin
		ce = 1'b0;
		sclk = 1'b0;
		sdi = 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// One byte, MSB first, 160 ns per bit; sdo taken at our rise
	task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic oe);
		oe = 1'b1;
		for (int i = 7; i >= 0; i--) begin
			@(posedge clk_sys) sdi <= tx[i];
			repeat (15) @(posedge clk_sys);
			sclk <= 1'b1;
			// Released line has no pull, so show the inverse of the last bit
			rx[i] = sdo_oe ? sdo : ~sdo;
			oe &= sdo_oe;
			repeat (16) @(posedge clk_sys);
			sclk <= 1'b0;
		end
	endtask

	// Address byte, then n data bytes in one select period
	task automatic xfer(input logic [7:0] a, input int n);
		logic [7:0] rx;
		logic o;
		@(posedge clk_sys) ce <= 1'b1;
		repeat (8) @(posedge clk_sys);
		byte_io(a, rx, o);
		oe_all = 1'b1;
		for (int k = 0; k < n; k++) begin
			byte_io(dat[k], rx, o);
			oe_all &= o;
			if (!a[7])
				dat[k] = rx;
		end
		repeat (16) @(posedge clk_sys);
		ce <= 1'b0;
		// Idle data line must not look like the last bit
		sdi <= ~sdi;
		repeat (8) @(posedge clk_sys);
	endtask

	// Four clock pulses, then select drops in mid-byte
	task automatic cut();
		@(posedge clk_sys) ce <= 1'b1;
		repeat (8) @(posedge clk_sys);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys) sdi <= 1'b1;
			repeat (15) @(posedge clk_sys);
			sclk <= 1'b1;
			repeat (16) @(posedge clk_sys);
			sclk <= 1'b0;
		end
		repeat (16) @(posedge clk_sys);
		ce <= 1'b0;
		repeat (8) @(posedge clk_sys);
	endtask
endmodule
`default_nettype wire

// [verif/bcd_rtc_calendar_alarms_test.sv]
// Self-checking bench for the BCD clock/calendar core
`timescale 1ns/100ps
`default_nettype none
module bcd_rtc_calendar_alarms_test;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic x1 = 1'b0;
	logic pfail = 1'b0;
	wire ce, sclk, sdi, sdo, sdo_oe, irq1_n, irq1_oe, irq2_n, irq2_oe;
	int error_cnt = 0;
	int total_checks = 0;

	always #2.5 clk_sys = ~clk_sys;

	brc_rtc_core #(.PRESCALE(4)) dut_u (.clk_sys(clk_sys), .rst(rst), .ce(ce), .sclk(sclk), .sdi(sdi),
		.x1(x1), .below_power_fail_threshold(pfail), .sdo(sdo), .sdo_oe(sdo_oe),
		.irq_out_first_n(irq1_n), .irq_out_first_oe(irq1_oe), .irq_out_second_n(irq2_n),
		.irq_out_second_oe(irq2_oe));
	brc_host_model host_u (.clk_sys(clk_sys), .sdo(sdo), .sdo_oe(sdo_oe), .ce(ce), .sclk(sclk), .sdi(sdi));

	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
		total_checks++;
		if (got !== ex) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", nm, ex, got);
		end
	endtask

	task automatic complete_run();
		if (error_cnt == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Four oscillator rises make one second at the reduced prescale
	task automatic secs(input int n);
		repeat (4 * n) begin
			@(posedge clk_sys) x1 <= 1'b1;
			repeat (4) @(posedge clk_sys);
			x1 <= 1'b0;
			repeat (4) @(posedge clk_sys);
		end
		repeat (8) @(posedge clk_sys);
	endtask

	task automatic wr1(input logic [6:0] a, input logic [7:0] v);
		host_u.dat[0] = v;
		host_u.xfer({1'b1, a}, 1);
	endtask

	task automatic rd1(input string nm, input logic [6:0] a, input logic [7:0] ex);
		host_u.xfer({1'b0, a}, 1);
		chk(nm, ex, host_u.dat[0]);
	endtask

	task automatic rd_time(input brc_pkg::brc_time_t ex);
		host_u.xfer(8'h00, 7);
		for (int k = 0; k < 7; k++)
			chk("time", ex[8*k+:8], host_u.dat[k]);
		chk("rd_oe", 8'h01, {7'h00, host_u.oe_all});
	endtask

	task automatic pins(input logic e1, input logic e2);
		chk("irq1", {7'h00, e1}, {7'h00, irq1_n});
		chk("irq2", {7'h00, e2}, {7'h00, irq2_n});
		chk("irq1_oe", {7'h00, ~e1}, {7'h00, irq1_oe});
		chk("irq2_oe", {7'h00, ~e2}, {7'h00, irq2_oe});
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd_time(56'h00010101000000);
		rd1("ctrl", 7'h0F, 8'h80);
		rd1("stat", 7'h10, 8'h00);
		pins(1'b1, 1'b1);
	endtask

	// Pairs of start time and time one second later
	task automatic t_roll();
		brc_pkg::brc_time_t tv [8] = '{56'h99123107235959, 56'h00810101000000,
			56'h04022803235959, 56'h04022904000000, 56'h05022801235959, 56'h05030102000000,
			56'h05043002715959, 56'h05050103520000};
		for (int c = 0; c < 8; c += 2) begin
			for (int k = 0; k < 7; k++)
				host_u.dat[k] = tv[c][8*k+:8];
			host_u.xfer(8'h80, 7);
			secs(1);
			rd_time(tv[c+1]);
		end
	endtask

	task automatic t_alarm();
		host_u.dat[0] = 8'h05;
		for (int k = 1; k < 8; k++)
			host_u.dat[k] = 8'h80;
		host_u.xfer(8'h87, 8);
		wr1(7'h0F, 8'h01);
		wr1(7'h00, 8'h04);
		secs(1);
		pins(1'b0, 1'b1);
		rd1("stat", 7'h10, 8'h03);
		wr1(7'h0F, 8'h06);
		pins(1'b0, 1'b0);
		wr1(7'h0F, 8'h02);
		pins(1'b1, 1'b0);
		wr1(7'h10, 8'h01);
		pins(1'b1, 1'b1);
		secs(1);
		pins(1'b1, 1'b0);
		wr1(7'h0F, 8'h00);
		pins(1'b1, 1'b1);
		secs(1);
		pins(1'b1, 1'b1);
		rd1("stat", 7'h10, 8'h03);
		for (int k = 0; k < 8; k++)
			host_u.dat[k] = 8'h00;
		host_u.xfer(8'h87, 8);
		wr1(7'h10, 8'h00);
		rd1("stat", 7'h10, 8'h00);
		secs(1);
		rd1("stat", 7'h10, 8'h00);
	endtask

	task automatic t_wrap();
		host_u.dat[0] = 8'hAA;
		host_u.dat[1] = 8'h33;
		host_u.xfer(8'h9F, 2);
		host_u.cut();
		rd1("sec", 7'h00, 8'h33);
		host_u.dat[0] = 8'h5A;
		host_u.dat[1] = 8'hA5;
		host_u.xfer(8'hFF, 2);
		host_u.xfer(8'h7F, 2);
		chk("ram_top", 8'h5A, host_u.dat[0]);
		chk("ram_bot", 8'hA5, host_u.dat[1]);
	endtask

	task automatic t_pfail();
		@(posedge clk_sys) pfail <= 1'b1;
		wr1(7'h01, 8'h45);
		host_u.xfer(8'h01, 1);
		chk("rd_oe", 8'h00, {7'h00, host_u.oe_all});
		wr1(7'h21, 8'h66);
		rd1("ram", 7'h21, 8'h66);
		@(posedge clk_sys) pfail <= 1'b0;
		rd1("min", 7'h01, 8'h00);
	endtask

	// Second ticks during the address byte, after the snapshot
	task automatic t_shadow();
		wr1(7'h00, 8'h10);
		fork
			host_u.xfer(8'h00, 1);
			begin
				repeat (40) @(posedge clk_sys);
				secs(1);
			end
		join
		chk("shadow", 8'h10, host_u.dat[0]);
		rd1("sec", 7'h00, 8'h11);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		t_reset();
		t_roll();
		t_alarm();
		t_wrap();
		t_pfail();
		t_shadow();
		complete_run();
	end

	initial begin
		repeat (100000) @(posedge clk_sys);
		error_cnt++;
		complete_run();
	end
endmodule
`default_nettype wire
